/* File: src/tll_pkg.sv */
// package: constants and carrier types for the three-wire latch loader
package tll_pkg;

	// ----------------------------------------
	// word layout
	// ----------------------------------------
	localparam int TLL_WORD_W = 24;
	localparam int TLL_SEL_LO = 0;
	localparam int TLL_SEL_HI = 1;

	// ----------------------------------------
	// latch select codes
	// ----------------------------------------
	localparam logic [1:0] TLL_SEL_CTRL = 2'h0;
	localparam logic [1:0] TLL_SEL_RCNT = 2'h1;
	localparam logic [1:0] TLL_SEL_NCNT = 2'h2;
	localparam logic [1:0] TLL_SEL_TEST = 2'h3;

	// ----------------------------------------
	// control latch fields (power-down and monitor source)
	// ----------------------------------------
	localparam int TLL_PD1_BIT = 20;
	localparam int TLL_PD2_BIT = 21;
	localparam int TLL_MON_LO = 5;
	localparam logic [TLL_WORD_W-1:0] TLL_LATCH_RST = 24'h00_0000;

	// monitor source codes
	localparam logic [2:0] TLL_MON_LOCK = 3'h1;
	localparam logic [2:0] TLL_MON_NDIV = 3'h2;
	localparam logic [2:0] TLL_MON_RDIV = 3'h4;

	// ----------------------------------------
	// band selection timing
	// ----------------------------------------
	localparam int TLL_BAND_CYCLES = 5;
	localparam logic [2:0] TLL_BAND_CNT_W3 = 3'h5;

	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef struct packed {
		logic sclk;
		logic sdata;
		logic load;
	} tll_serial_s;

	typedef struct packed {
		logic bypass_closed;
		logic in1_closed;
		logic in2_closed;
	} tll_refsw_s;

endpackage

/* File: src/tll_loader.sv */
// three-wire serial latch loader with power-down and monitor selection
module tll_loader
	import tll_pkg::*;
#(
	parameter int WORD_W = TLL_WORD_W
) (
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_in,
	// serial pins
	input wire tll_serial_s serial_in,
	input wire logic chip_enable_in,
	// internal analog-side status
	input wire logic lock_detect_in,
	input wire logic ndiv_scaled_in,
	input wire logic rdiv_scaled_in,
	input wire logic pfd_tick_in,
	// latch contents
	output logic [WORD_W-1:0] ctrl_latch_out,
	output logic [WORD_W-1:0] rcnt_latch_out,
	output logic [WORD_W-1:0] ncnt_latch_out,
	output logic [WORD_W-1:0] test_latch_out,
	// power and pins
	output logic powered_out,
	output logic charge_pump_oe_out,
	output tll_refsw_s ref_switch_out,
	output logic monitor_output_pin_out,
	output logic band_select_out
);

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	tll_serial_s ser_s1_r, ser_s2_r, ser_s3_r;
	logic ce_s1_r, ce_s2_r;

	always_ff @(posedge sys_clk_in) begin
		ser_s1_r <= serial_in;
		ser_s2_r <= ser_s1_r;
		ser_s3_r <= ser_s2_r;
		ce_s1_r <= chip_enable_in;
		ce_s2_r <= ce_s1_r;
	end

	// edge detection looks at the second and third stages only
	wire sclk_rise = ser_s2_r.sclk & ~ser_s3_r.sclk;
	wire load_rise = ser_s2_r.load & ~ser_s3_r.load;

	// ----------------------------------------
	// shift register
	// ----------------------------------------
	logic [WORD_W-1:0] shift_r;
	wire [WORD_W-1:0] shift_nxt = {shift_r[WORD_W-2:0], ser_s3_r.sdata};

	// data is taken from the third stage: one cycle older than the second-stage sclk sample that shows the edge
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			shift_r <= '0;
		end else if (sclk_rise) begin
			shift_r <= shift_nxt;
		end
	end

	shift_take_a: assert property (@(posedge sys_clk_in)
		disable iff (rst_in)
		sclk_rise |=> shift_r == $past(shift_nxt))
		else $error("shift register missed a serial clock edge");

	// ----------------------------------------
	// latch select decode
	// ----------------------------------------
	function automatic logic [3:0] sel_dec(input logic [1:0] sel);
		sel_dec = 4'h1 << sel;
	endfunction

	wire [1:0] latch_sel = {shift_r[TLL_SEL_HI], shift_r[TLL_SEL_LO]};
	wire [3:0] latch_hit = load_rise ? sel_dec(latch_sel) : 4'h0;

	logic [WORD_W-1:0] latch_r [4];

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_latch
			always_ff @(posedge sys_clk_in) begin
				if (rst_in) begin
					latch_r[gi] <= TLL_LATCH_RST;
				end else if (latch_hit[gi]) begin
					latch_r[gi] <= shift_r;
				end
			end
		end
	endgenerate

	// the test latch is stored but drives nothing internally
	assign ctrl_latch_out = latch_r[TLL_SEL_CTRL];
	assign rcnt_latch_out = latch_r[TLL_SEL_RCNT];
	assign ncnt_latch_out = latch_r[TLL_SEL_NCNT];
	assign test_latch_out = latch_r[TLL_SEL_TEST];

	latch_one_a: assert property (@(posedge sys_clk_in)
		disable iff (rst_in)
		$onehot0(latch_hit))
		else $error("more than one latch written");

	latch_hold_a: assert property (@(posedge sys_clk_in)
		disable iff (rst_in)
		!latch_hit[TLL_SEL_RCNT] |=> $stable(rcnt_latch_out))
		else $error("r counter latch changed without a load");

	test_hold_a: assert property (@(posedge sys_clk_in)
		disable iff (rst_in)
		!latch_hit[TLL_SEL_TEST] |=> $stable(test_latch_out))
		else $error("test latch changed without a load");

	ncnt_load_a: assert property (@(posedge sys_clk_in)
		disable iff (rst_in)
		load_rise && latch_sel == TLL_SEL_NCNT |=>
		ncnt_latch_out == $past(shift_r))
		else $error("n counter latch not loaded");

	// ----------------------------------------
	// power control
	// ----------------------------------------
	wire pd_bits_ok = ~ctrl_latch_out[TLL_PD1_BIT] &
		~ctrl_latch_out[TLL_PD2_BIT];
	wire power_nxt = ce_s2_r & pd_bits_ok;
	logic power_r;

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			power_r <= 1'b0;
		end else begin
			power_r <= power_nxt;
		end
	end

	assign powered_out = power_r;
	assign charge_pump_oe_out = power_r;
	// reference input disconnected whenever powered down
	assign ref_switch_out = {~power_r, power_r, power_r};

	cp_off_a: assert property (@(posedge sys_clk_in)
		disable iff (rst_in)
		!ce_s2_r |=> !charge_pump_oe_out)
		else $error("charge pump driven while disabled");

	pd_bits_a: assert property (@(posedge sys_clk_in)
		disable iff (rst_in)
		ce_s2_r && !pd_bits_ok |=> !powered_out)
		else $error("powered up against power-down bits");

	ref_sw_a: assert property (@(posedge sys_clk_in)
		disable iff (rst_in)
		!powered_out |-> ref_switch_out == 3'b100)
		else $error("reference input loaded in power-down");

	ref_on_a: assert property (@(posedge sys_clk_in)
		disable iff (rst_in)
		powered_out |-> ref_switch_out == 3'b011)
		else $error("reference input cut while powered");

	// ----------------------------------------
	// band selection
	// ----------------------------------------
	wire power_up = power_nxt & ~power_r;
	wire n_update = latch_hit[TLL_SEL_NCNT];
	logic [2:0] band_cnt_r;
	wire band_busy = band_cnt_r != 3'h0;

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			band_cnt_r <= 3'h0;
		end else if (~power_nxt) begin
			band_cnt_r <= 3'h0;
		end else if (power_up | n_update) begin
			band_cnt_r <= TLL_BAND_CNT_W3;
		end else if (band_busy & pfd_tick_in) begin
			band_cnt_r <= band_cnt_r - 3'h1;
		end
	end

	assign band_select_out = band_busy;

	band_start_a: assert property (@(posedge sys_clk_in)
		disable iff (rst_in)
		(n_update || power_up) && power_nxt |=>
		band_cnt_r == TLL_BAND_CNT_W3)
		else $error("band selection not started");

	band_step_a: assert property (@(posedge sys_clk_in)
		disable iff (rst_in)
		power_nxt && !power_up && !n_update && band_busy && pfd_tick_in
		|=> band_cnt_r == $past(band_cnt_r) - 3'h1)
		else $error("band selection missed a pfd cycle");

	// ----------------------------------------
	// monitor output
	// ----------------------------------------
	wire [2:0] mon_sel = ctrl_latch_out[TLL_MON_LO +: 3];
	wire mon_nxt = (mon_sel == TLL_MON_LOCK) ? lock_detect_in :
		(mon_sel == TLL_MON_NDIV) ? ndiv_scaled_in :
		(mon_sel == TLL_MON_RDIV) ? rdiv_scaled_in : 1'b0;
	logic mon_r;

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			mon_r <= 1'b0;
		end else begin
			mon_r <= mon_nxt;
		end
	end

	assign monitor_output_pin_out = mon_r;

	mon_lock_a: assert property (@(posedge sys_clk_in)
		disable iff (rst_in)
		mon_sel == TLL_MON_LOCK && $stable(mon_sel)
		|=> monitor_output_pin_out == $past(lock_detect_in))
		else $error("monitor pin not showing lock detect");

	mon_ndiv_a: assert property (@(posedge sys_clk_in)
		disable iff (rst_in)
		mon_sel == TLL_MON_NDIV
		|=> monitor_output_pin_out == $past(ndiv_scaled_in))
		else $error("monitor pin not showing scaled rf");

	mon_rdiv_a: assert property (@(posedge sys_clk_in)
		disable iff (rst_in)
		mon_sel == TLL_MON_RDIV
		|=> monitor_output_pin_out == $past(rdiv_scaled_in))
		else $error("monitor pin not showing scaled reference");

	mon_none_a: assert property (@(posedge sys_clk_in)
		disable iff (rst_in)
		mon_sel != TLL_MON_LOCK && mon_sel != TLL_MON_NDIV &&
		mon_sel != TLL_MON_RDIV |=> !monitor_output_pin_out)
		else $error("monitor pin active with no source selected");

endmodule

/* File: dv/tll_host.sv */
// host model: drives the three serial lines, msb first
module tll_host
	import tll_pkg::*;
(
	output tll_serial_s serial_out
);
	timeunit 1ns;
	timeprecision 1ps;
	initial serial_out = '0;
	// data after the last bit shows its inverse, never a stale copy
	task automatic send(input logic [23:0] w);
		for (int i = 23; i >= 0; i--) begin
			serial_out.sdata = w[i];
			#40 serial_out.sclk = 1'b1;
			#40 serial_out.sclk = 1'b0;
		end
		serial_out.sdata = ~w[0];
		#20 serial_out.load = 1'b1;
		#40 serial_out.load = 1'b0;
	endtask
endmodule

/* File: dv/tll_loader_test.sv */
// testbench for the three-wire latch loader
module tll_loader_test
	import tll_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// ----
	// bench state
	// ----
	logic clk = 0, rst = 1, ce = 0, lock = 0, tick = 0, bp = 0, nd = 0, rd = 0;
	logic pw, cpoe, mon, band;
	logic [23:0] cl, rl, nl, tl, w;
	logic [95:0] ex = '0, seen = '0, cur;
	logic [95:0] expq[$];
	tll_serial_s ser;
	tll_refsw_s sw;
	int fails = 0, cmp_count = 0, tc = 0, bt = 0;
	tll_host HOST (.serial_out(ser));
	tll_loader DUT (.sys_clk_in(clk), .rst_in(rst), .serial_in(ser),
		.chip_enable_in(ce), .lock_detect_in(lock), .ndiv_scaled_in(nd),
		.rdiv_scaled_in(rd), .pfd_tick_in(tick), .ctrl_latch_out(cl),
		.rcnt_latch_out(rl), .ncnt_latch_out(nl), .test_latch_out(tl),
		.powered_out(pw), .charge_pump_oe_out(cpoe), .ref_switch_out(sw),
		.monitor_output_pin_out(mon), .band_select_out(band));
	initial begin
		forever #2.5 clk = ~clk;
	end
	task automatic chk(input logic [95:0] got, input logic [95:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic close_out;
		$display("mismatches %0d compares %0d", fails, cmp_count);
		if (fails == 0 && cmp_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic wr(input logic [1:0] sel, input logic [23:0] d);
		d[1:0] = sel;
		ex[(3 - sel) * 24 +: 24] = d;
		expq.push_back(ex);
		// pins move 1 ns after an edge, like every other input except tick, which changes at the edge
		#1 HOST.send(d);
		repeat (8) @(posedge clk);
	endtask
	// ----
	// watchers: latch notes and band selection length
	// ----
	assign cur = {cl, rl, nl, tl};
	always @(posedge clk) begin
		tc <= (tc + 1) % 16;
		tick <= (tc == 0);
		if (!rst && cur !== seen) begin
			seen = cur;
			if (expq.size() == 0) chk(cur, ~cur);
			else chk(cur, expq.pop_front());
		end
		if (bp && band !== 1'b1) begin
			chk(96'(bt), 96'd5);
			bt = 0;
		end
		if (band === 1'b1 && tick) bt++;
		bp = (band === 1'b1);
	end
	initial begin
		#100us;
		fails++;
		close_out();
	end
	// ----
	// main sequence
	// ----
	initial begin
		void'($urandom(8652));
		repeat (16) @(posedge clk);
		#1 rst = 0;
		repeat (8) @(posedge clk);
		chk({pw, cpoe, sw}, 96'h04);
		#1 ce = 1;
		repeat (8) @(posedge clk);
		chk({pw, cpoe, sw}, 96'h1b);
		repeat (120) @(posedge clk);
		wr(TLL_SEL_RCNT, 24'($urandom));
		w = 24'($urandom);
		w[21:20] = 2'h0;
		// each monitor source in turn, with all three inputs randomised
		for (int m = 0; m < 3; m++) begin
			w[7:5] = (m == 0) ? TLL_MON_LOCK :
				(m == 1) ? TLL_MON_NDIV : TLL_MON_RDIV;
			wr(TLL_SEL_CTRL, w);
			for (int i = 0; i < 6; i++) begin
				#1 {lock, nd, rd} = 3'($urandom);
				repeat (3) @(posedge clk);
				chk(mon, (m == 0) ? lock : (m == 1) ? nd : rd);
			end
		end
		wr(TLL_SEL_NCNT, 24'($urandom));
		chk(band, 1'b1);
		repeat (120) @(posedge clk);
		// select 11 never goes on the wire: the test latch stays untouched
		wr(TLL_SEL_RCNT, 24'($urandom));
		w[20] = 1'b1;
		wr(TLL_SEL_CTRL, w);
		chk(pw, 1'b0);
		w[20] = 1'b0;
		wr(TLL_SEL_CTRL, w);
		chk({pw, band}, 96'h3);
		// band selection must finish first, or the length check sees a cut
		repeat (120) @(posedge clk);
		#1 ce = 0;
		repeat (8) @(posedge clk);
		chk({pw, cpoe, sw}, 96'h04);
		chk(96'(expq.size()), 96'h0);
		close_out();
	end
endmodule
